/* pkg/sac_pkg.sv */
// Contract
// - Start fall: busy low, result 10000000
// - Start reset acts while start held low
// - First conv edge after start high: MSB
// - Clear trial bit if DAC above input
// - Eight bits MSB first, busy high ninth
// - Result valid once busy returns high
// - Data tri-stated unless read enable high
// - Host keeps read low during conversion
// - Host may tie busy to read
// - Host holds start low 250ns minimum
// - 1.5us from start fall to MSB edge
// - Start rise 200ns from conv edge
// - Conversion takes nine converter clock periods
// - Host may read after nine clocks
// - Host gates decoded address with strobes
// - Host may use busy rise as interrupt
// - Converter clock runs only while busy low
package sac_pkg;
    localparam int          SAC_BITS         = 8;
    localparam int          SAC_CLK_MHZ      = 50;
    localparam int          SAC_START_NS     = 250;
    localparam int          SAC_SETTLE_NS    = 1500;
    localparam int          SAC_GUARD_NS     = 200;
    localparam int          SAC_CONV_PERIODS = 9;
    // Least times round up to whole 20 ns cycles
    localparam int          SAC_START_CYC    = (SAC_START_NS * SAC_CLK_MHZ + 999) / 1000;
    localparam int          SAC_SETTLE_CYC   = (SAC_SETTLE_NS * SAC_CLK_MHZ + 999) / 1000;
    localparam int          SAC_GUARD_CYC    = (SAC_GUARD_NS * SAC_CLK_MHZ + 999) / 1000;
    localparam int          SAC_HALF_CYC     = 25;
    localparam logic [7:0]  SAC_RESULT_RST   = 8'h80;
    localparam logic [7:0]  SAC_MSB_MASK     = 8'h80;
    typedef logic [SAC_BITS-1:0] sac_word_t;
endpackage

/* pkg/sac_if.sv */
`timescale 1ns/1ps
// Link between converter logic and host
interface sac_if;
    logic                   wr_n;      // Start pulse, active low
    logic                   conv_clk;  // Converter clock level from host
    logic                   busy_n;    // Low while converting
    logic                   rd;        // Read enable, active high
    logic                   cmp_high;  // Comparator: DAC above input
    sac_pkg::sac_word_t     dac_code;  // Trial code to DAC
    sac_pkg::sac_word_t     data_out;  // Data pin output values
    sac_pkg::sac_word_t     data_oe;   // Data pin output enables
    modport dev  (input wr_n, conv_clk, rd, cmp_high,
                  output busy_n, dac_code, data_out, data_oe);
    modport host (output wr_n, conv_clk, rd,
                  input busy_n, data_out, data_oe);
endinterface

/* verilog/sac_edge.sv */
`timescale 1ns/1ps
// Falling and rising edge detect of a synchronous level
module sac_edge (
    input  wire logic i_clk,   // System clock
    input  wire logic i_rst,   // Synchronous reset
    input  wire logic i_lvl,   // Level to watch
    output logic      o_fall,  // One-cycle fall pulse
    output logic      o_rise   // One-cycle rise pulse
);
    logic prev;
    // Previous level, reset high (idle)
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev <= 1'b1;
        end else begin
            prev <= i_lvl;
        end
    end
    assign o_fall = prev & ~i_lvl;
    assign o_rise = ~prev & i_lvl;
endmodule

/* verilog/sac_dev.sv */
`timescale 1ns/1ps
// Successive approximation control: the converter end
module sac_dev (
    input  wire logic i_clk,  // System clock
    input  wire logic i_rst,  // Synchronous reset
    sac_if.dev        lnk,    // Link to host
    output logic      o_done  // Conversion complete level
);
    import sac_pkg::*;
    sac_word_t result;
    sac_word_t trial;
    logic      busy;
    logic      clk_fall;
    // Converter clock falling edge
    sac_edge u_edge (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_lvl  (lnk.conv_clk),
        .o_fall (clk_fall),
        .o_rise ()
    );
    // Search register; start low overrides every clock edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            result <= SAC_RESULT_RST;
            trial  <= SAC_MSB_MASK;
            busy   <= 1'b0;
        end else if (!lnk.wr_n) begin
            result <= SAC_RESULT_RST;
            trial  <= SAC_MSB_MASK;
            busy   <= 1'b1;
        end else if (busy && clk_fall) begin
            if (trial == '0) begin
                busy <= 1'b0;
            end else begin
                // Drop bit on comparator high, raise next bit
                result <= (lnk.cmp_high ? (result & ~trial) : result)
                          | (trial >> 1);
                trial  <= trial >> 1;
            end
        end
    end
    // Pins: data driven only while read enable high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            // Idle after reset: busy high, so the host sees no false busy rise
            lnk.busy_n   <= 1'b1;
            lnk.dac_code <= SAC_RESULT_RST;
            lnk.data_out <= '0;
            lnk.data_oe  <= '0;
            o_done       <= 1'b1;
        end else begin
            lnk.busy_n   <= ~busy;
            lnk.dac_code <= result;
            lnk.data_out <= result;
            lnk.data_oe  <= {SAC_BITS{lnk.rd}};
            o_done       <= ~busy;
        end
    end
endmodule

/* verilog/sac_host.sv */
`timescale 1ns/1ps
// Host end: start pulse, gated converter clock, read
module sac_host (
    input  wire logic  i_clk,     // System clock
    input  wire logic  i_rst,     // Synchronous reset
    sac_if.host        lnk,       // Link to converter
    input  wire logic  i_cs,      // Decoded address
    input  wire logic  i_wr,      // Write strobe, starts conversion
    input  wire logic  i_rd,      // Read strobe
    output sac_pkg::sac_word_t o_data, // Captured result
    output logic       o_valid,   // Result captured pulse
    output logic       o_irq      // Busy rise pulse
);
    import sac_pkg::*;
    typedef enum {S_IDLE, S_LOW, S_SETTLE, S_RUN} sac_hst_t;
    sac_hst_t  state;
    logic [7:0] cnt;
    logic [5:0] half;
    logic      busy_rise;
    logic      clk_lvl;
    sac_edge u_busy (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_lvl  (lnk.busy_n),
        .o_fall (),
        .o_rise (busy_rise)
    );
    // Start and clock sequencing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state   <= S_IDLE;
            cnt     <= '0;
            half    <= '0;
            clk_lvl <= 1'b1;
            lnk.wr_n     <= 1'b1;
            lnk.conv_clk <= 1'b1;
        end else begin
            case (state)
                S_IDLE: begin
                    clk_lvl <= 1'b1;
                    lnk.conv_clk <= 1'b1;
                    if (i_cs && i_wr) begin
                        lnk.wr_n <= 1'b0;
                        cnt      <= 8'(SAC_START_CYC);
                        state    <= S_LOW;
                    end
                end
                S_LOW: begin
                    // Hold start low, then release with clock high
                    if (cnt <= 8'd1) begin
                        lnk.wr_n <= 1'b1;
                        cnt      <= 8'(SAC_SETTLE_CYC - SAC_START_CYC);
                        state    <= S_SETTLE;
                    end else begin
                        cnt <= cnt - 8'd1;
                    end
                end
                S_SETTLE: begin
                    if (cnt <= 8'd1) begin
                        half  <= 6'(SAC_HALF_CYC);
                        state <= S_RUN;
                    end else begin
                        cnt <= cnt - 8'd1;
                    end
                end
                S_RUN: begin
                    // Free clock until busy returns high
                    if (lnk.busy_n) begin
                        lnk.conv_clk <= 1'b1;
                        state        <= S_IDLE;
                    end else if (half <= 6'd1) begin
                        clk_lvl      <= ~clk_lvl;
                        lnk.conv_clk <= ~clk_lvl;
                        half         <= 6'(SAC_HALF_CYC);
                    end else begin
                        half <= half - 6'd1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
    // Read enable only outside conversion; capture result
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lnk.rd  <= 1'b0;
            o_data  <= '0;
            o_valid <= 1'b0;
            o_irq   <= 1'b0;
        end else begin
            lnk.rd  <= i_cs && i_rd && lnk.busy_n && state == S_IDLE;
            o_valid <= lnk.rd && (&lnk.data_oe);
            o_irq   <= busy_rise;
            if (lnk.rd && (&lnk.data_oe)) begin
                o_data <= lnk.data_out;
            end
        end
    end
endmodule

/* verif/sac_checker.sv */
`timescale 1ns/1ps
module sac_checker (
    input logic               i_clk,    // System clock
    input logic               i_rst,    // Synchronous reset
    input logic               wr_n,     // Start, active low
    input logic               conv_clk, // Converter clock
    input logic               busy_n,   // Low while converting
    input logic               rd,       // Read enable
    input sac_pkg::sac_word_t dac_code, // Trial code
    input sac_pkg::sac_word_t data_out, // Data pin values
    input sac_pkg::sac_word_t data_oe   // Data pin enables
);
    import sac_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic       clk_q;
    logic [3:0] falls;
    // Count converter clock falls since the last start
    always_ff @(posedge i_clk) begin
        clk_q <= conv_clk;
        if (i_rst || !wr_n) begin
            falls <= 4'h0;
        end else if (clk_q && !conv_clk && !busy_n) begin
            falls <= falls + 4'h1;
        end
    end
    property p_start; $fell(wr_n) |-> ##[1:3] (!busy_n && dac_code == 8'h80); endproperty
    a_start: assert property (p_start) else $error("start did not clear");
    property p_hold; (!wr_n && !$past(wr_n, 3)) |-> (!busy_n && dac_code == 8'h80); endproperty
    a_hold: assert property (p_hold) else $error("logic moved during start");
    property p_nine; $rose(busy_n) |-> falls == 4'h9; endproperty
    a_nine: assert property (p_nine) else $error("busy rose on wrong edge");
    property p_data; (busy_n && data_oe == 8'hff) |-> data_out == dac_code; endproperty
    a_data: assert property (p_data) else $error("driven data not result");
    property p_off; (!rd && !$past(rd)) |-> data_oe == 8'h00; endproperty
    a_off: assert property (p_off) else $error("data driven without read");
    property p_on; (rd && $past(rd)) |-> data_oe == 8'hff; endproperty
    a_on: assert property (p_on) else $error("data not driven on read");
    property p_keep; (rd && busy_n) |=> $stable(dac_code); endproperty
    a_keep: assert property (p_keep) else $error("read altered result");
    property p_done; (busy_n && $past(busy_n) && wr_n && $past(wr_n)) |-> $stable(dac_code); endproperty
    a_done: assert property (p_done) else $error("result moved after done");
    c_done: cover property ($rose(busy_n));
    c_read: cover property (busy_n && rd);
    c_again: cover property ($fell(wr_n) && busy_n);
endmodule

/* verif/tb_sar_adc_conversion_control.sv */
`timescale 1ns/1ps
module tb_sar_adc_conversion_control;
    import sac_pkg::*;
    logic         i_clk = 1'b0;
    logic         i_rst = 1'b1;
    logic         cs = 1'b0;
    logic         wr = 1'b0;
    logic         rd = 1'b0;
    logic         done;
    logic         valid;
    logic         irq;
    sac_word_t    data;
    sac_word_t    vin = 8'h00;
    int           mismatches = 0;
    int           comparisons = 0;
    int           n;
    logic [15:0]  rows [6] = '{16'h0000, 16'hffff, 16'h6666, 16'h8080, 16'h7f7f, 16'h0101};
    sac_if lnk ();
    sac_dev i_sac_dev (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .o_done(done));
    sac_host i_sac_host (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .i_cs(cs), .i_wr(wr),
        .i_rd(rd), .o_data(data), .o_valid(valid), .o_irq(irq));
    sac_checker i_sac_checker (.i_clk(i_clk), .i_rst(i_rst), .wr_n(lnk.wr_n),
        .conv_clk(lnk.conv_clk), .busy_n(lnk.busy_n), .rd(lnk.rd), .dac_code(lnk.dac_code),
        .data_out(lnk.data_out), .data_oe(lnk.data_oe));
    always #10 i_clk = ~i_clk;
    // Comparator: DAC code above the input
    always @(negedge i_clk) lnk.cmp_high <= lnk.dac_code > vin;
    task automatic chk(input sac_word_t got, input sac_word_t exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Bounded wait on a strobe seen at the falling edge
    task automatic wait_hi(input int which, input int lim);
        n = 0;
        while ((which ? valid : irq) !== 1'b1 && n < lim) begin
            @(negedge i_clk);
            n++;
        end
        if ((which ? valid : irq) !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic start(input sac_word_t v);
        @(negedge i_clk);
        vin = v;
        cs = 1'b1;
        wr = 1'b1;
        @(negedge i_clk);
        cs = 1'b0;
        wr = 1'b0;
    endtask
    task automatic read_chk(input sac_word_t exp);
        // Let the previous read's strobe fall before the next one
        repeat (3) @(negedge i_clk);
        cs = 1'b1;
        rd = 1'b1;
        wait_hi(1, 20);
        cs = 1'b0;
        rd = 1'b0;
        chk(data, exp);
    endtask
    // Main sequence: reset, table of inputs, mid-run reset
    initial begin
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        chk({4'h0, lnk.wr_n, lnk.conv_clk, lnk.rd, lnk.busy_n}, 8'h0d);
        chk(lnk.data_oe, 8'h00);
        foreach (rows[k]) begin
            start(rows[k][15:8]);
            wait_hi(0, 2000);
            chk({7'h00, lnk.busy_n}, 8'h01);
            read_chk(rows[k][7:0]);
            read_chk(rows[k][7:0]);
            chk({7'h00, done}, 8'h01);
            repeat (3) @(negedge i_clk);
            chk(lnk.data_oe, 8'h00);
        end
        start(8'h33);
        repeat (200) @(negedge i_clk);
        chk({6'h00, done, lnk.busy_n}, 8'h00);
        cs = 1'b1;
        rd = 1'b1;
        repeat (3) @(negedge i_clk);
        chk(lnk.data_oe, 8'h00);
        cs = 1'b0;
        rd = 1'b0;
        i_rst = 1'b1;
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        chk(lnk.dac_code, 8'h80);
        start(8'h5a);
        wait_hi(0, 2000);
        read_chk(8'h5a);
        test_done();
    end
endmodule
